// File: hdl/dcfo_pkg.sv
package dcfo_pkg;

    // data path and depth defaults
    localparam int DATA_W = 36;
    localparam int DEPTH_DEF = 512;
    localparam int STAGE_DEPTH = 8;

    // preset offsets loaded into both offset registers
    localparam int PRESET_HI = 64;
    localparam int PRESET_LO = 8;

    // flag-select codes {hi, lo} caught at reset release
    localparam logic [1:0] FS_SERIAL = 2'h3;
    localparam logic [1:0] FS_P64 = 2'h2;
    localparam logic [1:0] FS_P8 = 2'h1;
    localparam logic [1:0] FS_PAR = 2'h0;

    // flag values forced during reset
    localparam logic IR_RST = 1'h0;
    localparam logic OR_RST = 1'h0;
    localparam logic AE_N_RST = 1'h0;
    localparam logic AF_N_RST = 1'h1;

    // offset programming phases
    typedef enum logic [2:0] {
        PH_INIT,
        PH_SERIAL,
        PH_PAR_Y,
        PH_PAR_X,
        PH_RUN
    } dcfo_phase_t;

    // chip select, direction, enable and mailbox select of one port
    typedef struct packed {
        logic select_n;
        logic direction;
        logic enable;
        logic mailbox_sel;
    } dcfo_port_ctl_t;

endpackage

// File: hdl/dcfo_top.sv
`timescale 1ns/1ps
// Overview of operation
// - reset release picks serial, 64, 8 or parallel
// - preset modes raise input-ready two edges later
// - parallel mode: first two writes load Y, X
// - parallel offset uses low data bits, upper bits dropped
// - serial mode shifts one bit per enabled edge
// - serial chain is Y MSB first, X last
// - serial load keeps input-ready low until done
// - write port drives data on select and read-direction
// - five-way qualified write stores port data
// - read port drives data with inverted direction sense
// - five-way qualified read loads output register
// - output-ready low auto-loads next available word
// - pointers pass through two synchroniser stages to the flags
// - output-ready low keeps word, ignores reads
// - read pointer advances per loaded word
// - new word reaches output on third read edge
// - input-ready low ignores writes
// - write pointer advances per stored word
// - freed full location raises input-ready second edge
// - almost-empty compares count against X offset
// - almost-empty low while words at most X
// - almost-full low when count reaches depth minus Y
// - reset clears pointers and forces flag levels

////////////////////////////////////////////////////////////////////////////////

module dcfo_stage_fifo #(
    parameter int W = 36,
    parameter int D = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    // depth must be a power of two so the indices wrap on their own
    localparam int AW = $clog2(D);
    localparam logic [AW:0] D_P = (AW+1)'(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } dcfo_stage_st_t;

    dcfo_stage_st_t s_q, s_d;
    logic push, pop;

    assign in_ready = s_q.cnt < D_P;
    assign out_valid = s_q.cnt != '0;
    assign out_data = s_q.mem[s_q.rp];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = in_data;
            s_d.wp = s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        case ({push, pop})
            2'b10: s_d.cnt = s_q.cnt + 1'b1;
            2'b01: s_d.cnt = s_q.cnt - 1'b1;
            default: s_d.cnt = s_q.cnt;
        endcase
        if (!nrst) begin
            s_d.wp = '0;
            s_d.rp = '0;
            s_d.cnt = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        s_q <= s_d;
    end
endmodule // dcfo_stage_fifo

////////////////////////////////////////////////////////////////////////////////

module dcfo_top #(
    parameter int DEPTH = dcfo_pkg::DEPTH_DEF,
    parameter int WIDTH = dcfo_pkg::DATA_W
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // flag select pins, serial data and enable after reset
    input wire logic flag_select_lo,
    input wire logic flag_select_hi,
    // write port
    input wire dcfo_pkg::dcfo_port_ctl_t write_port_ctl,
    input wire logic [WIDTH-1:0] write_port_data_i,
    output logic [WIDTH-1:0] write_port_data_o,
    output logic write_port_data_oe_n,
    output logic input_ready_flag,
    output logic almost_full_flag_n,
    // read port
    input wire dcfo_pkg::dcfo_port_ctl_t read_port_ctl,
    output logic [WIDTH-1:0] read_port_data_o,
    output logic read_port_data_oe_n,
    output logic output_ready_flag,
    output logic almost_empty_flag_n
);
    import dcfo_pkg::*;

    localparam int OW = $clog2(DEPTH);
    localparam int PW = OW + 1;
    localparam int SCW = $clog2(2 * OW + 1);
    localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
    localparam logic [SCW-1:0] SER_LAST = SCW'(2 * OW - 1);

    typedef struct packed {
        logic [1:0] mode;
        dcfo_phase_t ph;
        logic [2*OW-1:0] ofs;        // {Y almost-full, X almost-empty}
        logic [SCW-1:0] ser_cnt;
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic [PW-1:0] ws1;
        logic [PW-1:0] ws2;
        logic [PW-1:0] rs1;
        logic [PW-1:0] rs2;
        logic [PW-1:0] stg;
        logic [WIDTH-1:0] out_word;
        logic [WIDTH-1:0] idle_word;
        logic or_q;
        logic ae_n_q;
        logic ir_q;
        logic af_n_q;
    } dcfo_state_t;

    dcfo_state_t s_q, s_d;

    function automatic logic [PW-1:0] ptr_diff(input logic [PW-1:0] a, input logic [PW-1:0] b);
        return a - b;
    endfunction

    logic serial_offset_data, serial_offset_enable_n;
    logic wr_sel, wr_acc, rd_sel, rd_avail, rd_load, mem_we;
    logic st_in_valid, st_in_ready, st_out_valid, st_out_ready;
    logic [WIDTH-1:0] st_out_data;
    logic [PW-1:0] ofs_x, ofs_y;

    // the select pins double as the serial load pair once out of reset
    assign serial_offset_data = flag_select_lo;
    assign serial_offset_enable_n = flag_select_hi;
    assign ofs_y = {1'b0, s_q.ofs[2*OW-1:OW]};
    assign ofs_x = {1'b0, s_q.ofs[OW-1:0]};

    ////////////////////////////////////////////////////////////////////////////
    // port decode

    assign wr_sel = !write_port_ctl.select_n && !write_port_ctl.mailbox_sel
        && write_port_ctl.direction && write_port_ctl.enable;
    assign rd_sel = !read_port_ctl.select_n && !read_port_ctl.mailbox_sel
        && read_port_ctl.direction && read_port_ctl.enable;
    // staging room is part of the ready flag so a full stage stalls writers
    assign input_ready_flag = s_q.ir_q && (s_q.ph != PH_RUN || st_in_ready);
    assign wr_acc = wr_sel && input_ready_flag;
    assign st_in_valid = wr_acc && s_q.ph == PH_RUN;
    // drain only while memory holds a free slot as seen by the write side
    assign st_out_ready = ptr_diff(s_q.wptr, s_q.rs2) < DEPTH_P;
    assign mem_we = st_out_valid && st_out_ready;
    assign rd_avail = ptr_diff(s_q.ws2, s_q.rptr) != '0;
    assign rd_load = rd_avail && (!s_q.or_q || rd_sel);

    assign write_port_data_oe_n = !(!write_port_ctl.select_n
        && !write_port_ctl.direction);
    assign write_port_data_o = s_q.idle_word;
    assign read_port_data_oe_n = !(!read_port_ctl.select_n
        && read_port_ctl.direction);
    assign read_port_data_o = s_q.out_word;
    assign output_ready_flag = s_q.or_q;
    assign almost_empty_flag_n = s_q.ae_n_q;
    assign almost_full_flag_n = s_q.af_n_q;

    dcfo_stage_fifo #(
        .W(WIDTH),
        .D(STAGE_DEPTH)
    ) u_stage (
        .core_clk(core_clk),
        .nrst(nrst),
        .in_valid(st_in_valid),
        .in_ready(st_in_ready),
        .in_data(write_port_data_i),
        .out_valid(st_out_valid),
        .out_ready(st_out_ready),
        .out_data(st_out_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_d = s_q;
        // offset programming
        case (s_q.ph)
            PH_INIT: begin
                case (s_q.mode)
                    FS_SERIAL: s_d.ph = PH_SERIAL;
                    FS_PAR: s_d.ph = PH_PAR_Y;
                    FS_P64: begin
                        s_d.ofs = {OW'(PRESET_HI), OW'(PRESET_HI)};
                        s_d.ph = PH_RUN;
                    end
                    default: begin
                        s_d.ofs = {OW'(PRESET_LO), OW'(PRESET_LO)};
                        s_d.ph = PH_RUN;
                    end
                endcase
            end
            PH_SERIAL: begin
                if (!serial_offset_enable_n) begin
                    s_d.ofs = {s_q.ofs[2*OW-2:0], serial_offset_data};
                    s_d.ser_cnt = s_q.ser_cnt + 1'b1;
                    if (s_q.ser_cnt == SER_LAST) begin
                        s_d.ph = PH_RUN;
                    end
                end
            end
            PH_PAR_Y: begin
                if (wr_acc) begin
                    s_d.ofs[2*OW-1:OW] = write_port_data_i[OW-1:0];
                    s_d.ph = PH_PAR_X;
                end
            end
            PH_PAR_X: begin
                if (wr_acc) begin
                    s_d.ofs[OW-1:0] = write_port_data_i[OW-1:0];
                    s_d.ph = PH_RUN;
                end
            end
            default: s_d.ph = PH_RUN;
        endcase
        // memory write from the staging buffer
        if (mem_we) begin
            s_d.mem[s_q.wptr[PW-2:0]] = st_out_data;
            s_d.wptr = s_q.wptr + 1'b1;
        end
        // staged words are owed a slot, else a freed slot goes to them, not the writer
        s_d.stg = s_q.stg + {{(PW-1){1'b0}}, st_in_valid} - {{(PW-1){1'b0}}, mem_we};
        // output register
        if (rd_load) begin
            s_d.out_word = s_q.mem[s_q.rptr[PW-2:0]];
            s_d.rptr = s_q.rptr + 1'b1;
            s_d.or_q = 1'b1;
        end else if (s_q.or_q && rd_sel) begin
            s_d.or_q = 1'b0;
        end
        // two-stage pointer crossings; first stages feed only the second
        s_d.ws1 = s_q.wptr;
        s_d.ws2 = s_q.ws1;
        s_d.rs1 = s_d.rptr;
        s_d.rs2 = s_q.rs1;
        // flags
        s_d.ae_n_q = ptr_diff(s_q.ws2, s_d.rptr) > ofs_x;
        s_d.ir_q = (s_q.ph == PH_RUN || s_q.ph == PH_PAR_Y || s_q.ph == PH_PAR_X)
            && ptr_diff(s_d.wptr, s_q.rs2) + s_d.stg < DEPTH_P;
        s_d.af_n_q = ptr_diff(s_d.wptr, s_q.rs2) < DEPTH_P - ofs_y;
        if (!nrst) begin
            // selects are caught every reset cycle; the last one counts
            s_d.mode = {flag_select_hi, flag_select_lo};
            s_d.ph = PH_INIT;
            s_d.ofs = '0;
            s_d.ser_cnt = '0;
            s_d.wptr = '0;
            s_d.rptr = '0;
            s_d.ws1 = '0;
            s_d.ws2 = '0;
            s_d.rs1 = '0;
            s_d.rs2 = '0;
            s_d.stg = '0;
            s_d.out_word = '0;
            s_d.idle_word = '0;
            s_d.or_q = OR_RST;
            s_d.ae_n_q = AE_N_RST;
            s_d.ir_q = IR_RST;
            s_d.af_n_q = AF_N_RST;
        end
    end

    always_ff @(posedge core_clk) begin
        s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    AST_RESET_FLAGS: assert property (disable iff (1'b0)
        !nrst |=> !input_ready_flag && !output_ready_flag && !almost_empty_flag_n
            && almost_full_flag_n && s_q.wptr == '0 && s_q.rptr == '0)
        else $error("flags or pointers wrong after reset");

    AST_MODE_PICK: assert property (
        s_q.ph == PH_INIT |=> s_q.ph == (($past(s_q.mode) == FS_SERIAL) ? PH_SERIAL
            : ($past(s_q.mode) == FS_PAR) ? PH_PAR_Y : PH_RUN))
        else $error("offset mode not taken from flag selects");

    AST_PRESET_READY: assert property (
        s_q.ph == PH_INIT && (s_q.mode == FS_P64 || s_q.mode == FS_P8)
            |=> !s_q.ir_q ##1 s_q.ir_q)
        else $error("preset mode ready not on second edge");

    AST_SERIAL_HOLD: assert property (
        s_q.ph == PH_SERIAL |-> !input_ready_flag)
        else $error("input ready high during serial load");

    AST_SERIAL_DONE: assert property (
        s_q.ph == PH_SERIAL && !serial_offset_enable_n && s_q.ser_cnt == SER_LAST
            |=> s_q.ph == PH_RUN && !s_q.ir_q ##1 s_q.ir_q)
        else $error("input ready not raised after last serial bit");

    AST_WRITE_IGNORED: assert property (
        !input_ready_flag && s_q.ph != PH_INIT
            |-> !st_in_valid && s_d.ofs == s_q.ofs || s_q.ph == PH_SERIAL)
        else $error("write taken while input ready low");

    AST_IR_FULL: assert property (
        ptr_diff(s_q.wptr, s_q.rs2) == DEPTH_P |-> !input_ready_flag)
        else $error("input ready high while memory full");

    AST_AF_LEVEL: assert property (
        s_q.ph == PH_RUN && ptr_diff(s_q.wptr, s_q.rs2) >= DEPTH_P - ofs_y
            |=> !almost_full_flag_n)
        else $error("almost full not low at threshold");

    AST_READ_ADVANCE: assert property (
        s_q.or_q && rd_sel && rd_avail |=> s_q.rptr == $past(s_q.rptr) + 1'b1 && s_q.or_q)
        else $error("selected read did not advance");

    AST_OR_HOLD: assert property (
        s_q.or_q && rd_sel && !rd_avail
            |=> !s_q.or_q && $stable(s_q.out_word) ##1 $stable(s_q.out_word) || s_q.or_q)
        else $error("output word changed while not ready");

    AST_OR_LATENCY: assert property (
        mem_we && !s_q.or_q && s_q.wptr == s_q.rptr && s_q.ws2 == s_q.rptr
            |=> !s_q.or_q [*3] ##1 s_q.or_q)
        else $error("first word not shown on third read edge");

    AST_IR_RECOVER: assert property (
        s_q.ph == PH_RUN && rd_load && ptr_diff(s_q.wptr, s_q.rptr) == DEPTH_P
            && s_q.rs2 == s_q.rptr |=> !s_q.ir_q [*2] ##1 s_q.ir_q)
        else $error("input ready not back on second edge after read");

    COV_PRESET: cover property (s_q.ph == PH_INIT && s_q.mode == FS_P64 ##2 s_q.ir_q);
    COV_PARALLEL: cover property (s_q.ph == PH_PAR_X && wr_acc);
    COV_SERIAL: cover property (s_q.ph == PH_SERIAL ##1 s_q.ph == PH_RUN);
    COV_FULL: cover property (!s_q.ir_q && s_q.ph == PH_RUN);
    COV_READ: cover property (s_q.or_q && rd_sel && rd_avail);

endmodule // dcfo_top

// File: testbench/dcfo_read_partner.sv
`timescale 1ns/1ps
module dcfo_read_partner (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // bench control
    input wire logic go,
    // device read port
    output dcfo_pkg::dcfo_port_ctl_t read_port_ctl,
    input wire logic [dcfo_pkg::DATA_W-1:0] read_port_data_o,
    input wire logic output_ready_flag
);
    import dcfo_pkg::*;

    logic [DATA_W-1:0] got[$];

    ////////////////////////////////////////////////////////////////////////////////

    // a taken read consumes the word shown before the edge
    always @(posedge core_clk) begin
        if (nrst && read_port_ctl.enable && output_ready_flag) begin
            got.push_back(read_port_data_o);
        end
        // selects only move while enable is low, never mid-transfer
        if (!nrst || !go) begin
            read_port_ctl <= 4'h4;
        end else begin
            read_port_ctl <= 4'h6;
        end
    end
endmodule // dcfo_read_partner

// File: testbench/dcfo_top_tb.sv
`timescale 1ns/1ps
module dcfo_top_tb;
    import dcfo_pkg::*;

    localparam dcfo_port_ctl_t W_IDLE = 4'hc;
    localparam dcfo_port_ctl_t W_WR = 4'h6;
    localparam dcfo_port_ctl_t W_MB = 4'h7;
    localparam dcfo_port_ctl_t W_RD = 4'h0;

    logic core_clk;
    logic nrst;
    logic fs_lo;
    logic fs_hi;
    logic go;
    dcfo_port_ctl_t w_ctl;
    dcfo_port_ctl_t r_ctl;
    logic [DATA_W-1:0] w_data;
    logic [DATA_W-1:0] w_out;
    logic [DATA_W-1:0] r_data;
    logic w_oe_n;
    logic r_oe_n;
    logic ir;
    logic orf;
    logic ae_n;
    logic af_n;
    logic [DATA_W-1:0] exp_q[$];
    int err_count;
    int n_tests;
    int k;
    logic ok;

    dcfo_top #(.DEPTH(512), .WIDTH(DATA_W)) dcfo_top_inst (
        .core_clk(core_clk), .nrst(nrst),
        .flag_select_lo(fs_lo), .flag_select_hi(fs_hi),
        .write_port_ctl(w_ctl), .write_port_data_i(w_data),
        .write_port_data_o(w_out), .write_port_data_oe_n(w_oe_n),
        .input_ready_flag(ir), .almost_full_flag_n(af_n),
        .read_port_ctl(r_ctl), .read_port_data_o(r_data),
        .read_port_data_oe_n(r_oe_n), .output_ready_flag(orf),
        .almost_empty_flag_n(ae_n)
    );

    dcfo_read_partner dcfo_read_partner_inst (
        .core_clk(core_clk), .nrst(nrst), .go(go), .read_port_ctl(r_ctl),
        .read_port_data_o(r_data), .output_ready_flag(orf)
    );

    ////////////////////////////////////////////////////////////////////////////////

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // flag selects double as mode pins during reset
    task automatic rst(input logic [1:0] fs);
        nrst <= 1'b0;
        {fs_hi, fs_lo} <= fs;
        w_ctl <= W_IDLE;
        go <= 1'b0;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        chk(ir, IR_RST);
        chk(orf, OR_RST);
        chk({ae_n, af_n}, {AE_N_RST, AF_N_RST});
        @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        @(negedge core_clk);
        chk(ir, 1'b0);
        @(posedge core_clk);
        @(negedge core_clk);
        chk(ir, fs != FS_SERIAL);
        @(posedge core_clk);
        dcfo_read_partner_inst.got.delete();
        exp_q.delete();
    endtask

    // request held until an edge that sees input-ready high
    task automatic wr(input logic [DATA_W-1:0] d);
        int n;
        w_ctl <= W_WR;
        w_data <= d;
        for (n = 0; n < 2000; n++) begin
            @(negedge core_clk);
            if (ir === 1'b1) break;
        end
        @(posedge core_clk);
        if (n == 2000) begin
            err_count++;
            give_verdict();
        end
    endtask

    task automatic wrs(input logic [DATA_W-1:0] base, input int n);
        for (int i = 0; i < n; i++) begin
            wr(base + DATA_W'(i));
            exp_q.push_back(base + DATA_W'(i));
        end
        w_ctl <= W_IDLE;
        repeat (12) @(posedge core_clk);
    endtask

    task automatic drain(input int n);
        go <= 1'b1;
        repeat (n) @(posedge core_clk);
        go <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk(DATA_W'(dcfo_read_partner_inst.got.size()), DATA_W'(exp_q.size()));
        foreach (exp_q[i]) chk(dcfo_read_partner_inst.got[i], exp_q[i]);
        dcfo_read_partner_inst.got.delete();
        exp_q.delete();
    endtask

    ////////////////////////////////////////////////////////////////////////////////

    initial begin
        err_count = 0;
        n_tests = 0;
        nrst = 1'b0;
        fs_lo = 1'b0;
        fs_hi = 1'b0;
        go = 1'b0;
        w_ctl = W_IDLE;
        w_data = '0;
        @(posedge core_clk);
        // preset 8: port direction, refused mailbox write, first-word latency
        rst(FS_P8);
        @(negedge core_clk);
        chk(w_oe_n, 1'b1);
        chk(r_oe_n, 1'b0);
        @(posedge core_clk);
        w_ctl <= W_RD;
        w_data <= 36'hbad;
        @(negedge core_clk);
        chk(w_oe_n, 1'b0);
        chk(w_out, 36'h0);
        @(posedge core_clk);
        w_ctl <= W_MB;
        @(posedge core_clk);
        wr(36'h1);
        exp_q.push_back(36'h1);
        w_ctl <= W_IDLE;
        @(posedge core_clk);
        for (k = 1; k <= 4; k++) begin
            @(negedge core_clk);
            chk(orf, k == 4);
            @(posedge core_clk);
        end
        chk(r_data, 36'h1);
        wrs(36'h2, 9);
        chk(ae_n, 1'b1);
        drain(30);
        @(negedge core_clk);
        chk({orf, ae_n}, 2'h0);
        chk(r_data, 36'ha);
        @(posedge core_clk);
        // preset 64: fill until refused, free one slot, drain
        rst(FS_P64);
        w_ctl <= W_WR;
        for (k = 0; k < 560; k++) begin
            w_data <= DATA_W'(k);
            @(negedge core_clk);
            ok = ir;
            @(posedge core_clk);
            if (ok) exp_q.push_back(DATA_W'(k));
        end
        w_ctl <= W_IDLE;
        @(negedge core_clk);
        chk({ir, af_n}, 2'h0);
        @(posedge core_clk);
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        for (k = 0; k < 5 && ir !== 1'b1; k++) @(negedge core_clk);
        chk(ir, 1'b1);
        chk(DATA_W'(k), 36'h4);
        @(posedge core_clk);
        drain(600);
        // serial: Y then X, one 18-bit chain, MSB first
        rst(FS_SERIAL);
        for (k = 17; k >= 0; k--) begin
            fs_hi <= 1'b0;
            fs_lo <= (k == 11 || k == 9 || k == 1 || k == 0);
            @(negedge core_clk);
            chk(ir, 1'b0);
            @(posedge core_clk);
        end
        fs_hi <= 1'b1;
        @(negedge core_clk);
        chk(ir, 1'b0);
        @(posedge core_clk);
        @(negedge core_clk);
        chk(ir, 1'b1);
        @(posedge core_clk);
        exp_q.delete();
        wrs(36'hc0, 5);
        chk(ae_n, 1'b1);
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk(ae_n, 1'b0);
        drain(20);
        // parallel: upper data bits must not reach the offsets
        rst(FS_PAR);
        wr(36'hffffffff4);
        wr(36'hffffffe03);
        wrs(36'ha0, 4);
        chk({ae_n, af_n}, 2'h1);
        wrs(36'ha4, 10);
        chk({ae_n, af_n}, 2'h2);
        drain(30);
        give_verdict();
    end
endmodule // dcfo_top_tb
